/* File: shared/hcm_params.svh */
/*
 Offsets, field positions, reset values and timing counts for the calibration, monitor
 and waveform memory register group. Assumes a 40 MHz core clock.
*/
// What this block does
// (RQ1) Calibration time is bits 5-4, default 2: 150-350, 250-450, 500-700 or 1000-1200 ms.
// (RQ2) Software picks a duration in which actuator acceleration settles at nominal drive.
// (RQ3) Control bit 2 is read-only: 0 before and 1 after the one-time memory is programmed.
// (RQ4) Writing one to bit 0 starts copying registers 0x16 to 0x1A into the one-time memory.
// (RQ5) Programming succeeds only once per device, and later launches are refused.
// (RQ6) The supply reading is an 8-bit code where volts equal code times 5.6 V over 255.
// (RQ7) The supply and period readings refresh only while a waveform is being driven.
// (RQ8) The resonance period reading is an 8-bit code where microseconds equal code times 98.46.
// (RQ9) The upper waveform memory address byte is read/write at 0xFD, reset to zero.
// (RQ10) The lower waveform memory address byte is read/write at 0xFE, reset to zero.
// (RQ11) A byte written to 0xFF is stored at the address formed by the upper and lower bytes.
// (RQ12) Each byte stored through 0xFF increments the combined address by one.
// (RQ13) The host may load the memory one byte per transaction or as a burst to 0xFF.
// (RQ14) Reserved bits of the control register read as zero and ignore writes.
`ifndef HCM_PARAMS_SVH
`define HCM_PARAMS_SVH

`define HCM_OFS_CTRL        8'h1E
`define HCM_OFS_SUPPLY      8'h21
`define HCM_OFS_PERIOD      8'h22
`define HCM_OFS_ADDR_HI     8'hFD
`define HCM_OFS_ADDR_LO     8'hFE
`define HCM_OFS_DATA        8'hFF
`define HCM_OFS_NVM_FIRST   8'h16
`define HCM_OFS_NVM_LAST    8'h1A

`define HCM_CAL_LSB         4
`define HCM_CAL_MSB         5
`define HCM_NVM_DONE_BIT    2
`define HCM_NVM_GO_BIT      0
`define HCM_CAL_RESET       2'h2

`define HCM_CLK_MHZ         40
`define HCM_CAL0_MIN_MS     150
`define HCM_CAL1_MIN_MS     250
`define HCM_CAL2_MIN_MS     500
`define HCM_CAL3_MIN_MS     1000
`define HCM_MS_CYCLES       (`HCM_CLK_MHZ * 1000)

`endif

/* File: shared/hcm_pkg.sv */
/*
 Types shared by the register group and its waveform memory FIFO.
 Assumes the constants header is included alongside.
*/
package hcm_pkg;
    typedef enum logic [1:0] {
        HCM_NVM_IDLE,
        HCM_NVM_COPY,
        HCM_NVM_DONE
    } hcm_nvm_state_t;
endpackage : hcm_pkg

/* File: shared/hcm_wr_if.sv */
/*
 Carrier for waveform memory write words between the register group and its FIFO.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface hcm_wr_if #(parameter int WIDTH = 24) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : hcm_wr_if
`default_nettype wire

/* File: core/hcm_fifo.sv */
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hcm_fifo
    import hcm_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    hcm_wr_if.sink                in_port,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  full_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("hcm_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    assign full_o        = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
                           && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign out_valid_o   = wr_ptr_reg != rd_ptr_reg;
    assign in_port.ready = !full_o;
    assign push          = in_port.valid && !full_o;
    assign pop           = out_valid_o && out_ready_i;
    assign out_data_o    = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_port.data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    a_no_overflow: assert property (@(posedge core_clk_i) disable iff (srst_i)
        full_o |=> !(wr_ptr_reg != $past(wr_ptr_reg)))
        else $error("FIFO written while full");
endmodule : hcm_fifo
`default_nettype wire

/* File: core/hcm_regs.sv */
/*
 Calibration selector, one-time memory status and launch, supply and resonance monitors,
 and the indirect waveform memory write port. Assumes a serial bus front end that
 delivers one byte write or read strobe per cycle with an 8-bit register offset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hcm_params.svh"
module hcm_regs
    import hcm_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int NVM_BYTES  = 5
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_wr_ready_o,
    input  wire logic        playing_i,
    input  wire logic        monitor_strobe_i,
    input  wire logic [7:0]  supply_sample_i,
    input  wire logic [7:0]  period_sample_i,
    input  wire logic        nvm_programmed_i,
    output logic             nvm_copy_o,
    output logic      [7:0]  nvm_copy_addr_o,
    input  wire logic        nvm_copy_ack_i,
    output logic      [1:0]  cal_time_sel_o,
    output logic      [31:0] cal_min_cycles_o,
    output logic             wave_valid_o,
    input  wire logic        wave_ready_i,
    output logic      [15:0] wave_addr_o,
    output logic      [7:0]  wave_data_o
);
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("hcm_regs needs a FIFO of at least two words");
    end
    if (NVM_BYTES != 5) begin : g_bad_nvm
        $error("hcm_regs copies exactly five bytes");
    end

    logic [1:0]     cal_sel_reg;
    logic           nvm_done_reg;
    hcm_nvm_state_t nvm_state_reg;
    logic [7:0]     nvm_addr_reg;
    logic [7:0]     supply_reg;
    logic [7:0]     period_reg;
    logic [7:0]     addr_hi_reg;
    logic [7:0]     addr_lo_reg;
    logic [7:0]     data_reg;
    logic [15:0]    addr_next;
    logic           wr_data;
    logic           fifo_full;
    logic [23:0]    fifo_out;

    hcm_wr_if #(.WIDTH(24)) wr_bus ();

    // A data write is only taken while the FIFO has room; the bus front end holds off.
    assign reg_wr_ready_o = !fifo_full;
    assign wr_data   = reg_wr_i && reg_addr_i == `HCM_OFS_DATA && wr_bus.ready;
    assign addr_next = {addr_hi_reg, addr_lo_reg} + 16'h0001;

    // Control register: only the calibration field is writable. [RQ14]
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cal_sel_reg <= `HCM_CAL_RESET;
        end else if (reg_wr_i && reg_addr_i == `HCM_OFS_CTRL) begin
            cal_sel_reg <= reg_wdata_i[`HCM_CAL_MSB:`HCM_CAL_LSB]; // [RQ1]
        end
    end

    assign cal_time_sel_o = cal_sel_reg;

    // Least time of each window, so calibration never ends early. [RQ1]
    always_comb begin
        unique case (cal_sel_reg)
            2'h0: cal_min_cycles_o = 32'(`HCM_CAL0_MIN_MS * `HCM_MS_CYCLES);
            2'h1: cal_min_cycles_o = 32'(`HCM_CAL1_MIN_MS * `HCM_MS_CYCLES);
            2'h2: cal_min_cycles_o = 32'(`HCM_CAL2_MIN_MS * `HCM_MS_CYCLES);
            2'h3: cal_min_cycles_o = 32'(`HCM_CAL3_MIN_MS * `HCM_MS_CYCLES);
        endcase
    end

    // One-time copy of the calibration registers; refused once programmed.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            nvm_state_reg <= HCM_NVM_IDLE;
            nvm_addr_reg  <= `HCM_OFS_NVM_FIRST;
            nvm_done_reg  <= 1'b0;
        end else begin
            unique case (nvm_state_reg)
                HCM_NVM_IDLE: begin
                    if (nvm_programmed_i) begin
                        nvm_done_reg  <= 1'b1; // [RQ3]
                        nvm_state_reg <= HCM_NVM_DONE;
                    end else if (reg_wr_i && reg_addr_i == `HCM_OFS_CTRL
                                 && reg_wdata_i[`HCM_NVM_GO_BIT]) begin
                        nvm_state_reg <= HCM_NVM_COPY; // [RQ4]
                        nvm_addr_reg  <= `HCM_OFS_NVM_FIRST;
                    end
                end
                HCM_NVM_COPY: begin
                    if (nvm_copy_ack_i) begin
                        if (nvm_addr_reg == `HCM_OFS_NVM_LAST) begin
                            nvm_state_reg <= HCM_NVM_DONE;
                            nvm_done_reg  <= 1'b1; // [RQ3]
                        end else begin
                            nvm_addr_reg <= nvm_addr_reg + 8'h01; // [RQ4]
                        end
                    end
                end
                HCM_NVM_DONE: begin
                    nvm_state_reg <= HCM_NVM_DONE; // [RQ5]
                end
            endcase
        end
    end

    assign nvm_copy_o      = nvm_state_reg == HCM_NVM_COPY;
    assign nvm_copy_addr_o = nvm_addr_reg;

    // Monitors refresh only while a waveform plays; software writes land unless a refresh takes the same cycle.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            supply_reg <= 8'h00;
            period_reg <= 8'h00;
        end else if (playing_i && monitor_strobe_i) begin
            supply_reg <= supply_sample_i; // [RQ6] [RQ7]
            period_reg <= period_sample_i; // [RQ8] [RQ7]
        end else if (reg_wr_i && reg_addr_i == `HCM_OFS_SUPPLY) begin
            supply_reg <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == `HCM_OFS_PERIOD) begin
            period_reg <= reg_wdata_i;
        end
    end

    // Address bytes; a data write advances the pair, bursts included.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            addr_hi_reg <= 8'h00; // [RQ9]
            addr_lo_reg <= 8'h00; // [RQ10]
        end else if (wr_data) begin
            addr_hi_reg <= addr_next[15:8]; // [RQ12] [RQ13]
            addr_lo_reg <= addr_next[7:0];
        end else if (reg_wr_i && reg_addr_i == `HCM_OFS_ADDR_HI) begin
            addr_hi_reg <= reg_wdata_i; // [RQ9]
        end else if (reg_wr_i && reg_addr_i == `HCM_OFS_ADDR_LO) begin
            addr_lo_reg <= reg_wdata_i; // [RQ10]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            data_reg <= 8'h00;
        end else if (wr_data) begin
            data_reg <= reg_wdata_i;
        end
    end

    assign wr_bus.valid = reg_wr_i && reg_addr_i == `HCM_OFS_DATA;
    assign wr_bus.data  = {addr_hi_reg, addr_lo_reg, reg_wdata_i}; // [RQ11]

    hcm_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i  (core_clk_i),
        .srst_i      (srst_i),
        .in_port     (wr_bus),
        .out_valid_o (wave_valid_o),
        .out_ready_i (wave_ready_i),
        .out_data_o  (fifo_out),
        .full_o      (fifo_full)
    );

    assign wave_addr_o = fifo_out[23:8];
    assign wave_data_o = fifo_out[7:0];

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `HCM_OFS_CTRL:    reg_rdata_o <= {2'b00, cal_sel_reg, 1'b0,
                                                  nvm_done_reg, 2'b00}; // [RQ14] [RQ3]
                `HCM_OFS_SUPPLY:  reg_rdata_o <= supply_reg;
                `HCM_OFS_PERIOD:  reg_rdata_o <= period_reg;
                `HCM_OFS_ADDR_HI: reg_rdata_o <= addr_hi_reg;
                `HCM_OFS_ADDR_LO: reg_rdata_o <= addr_lo_reg;
                `HCM_OFS_DATA:    reg_rdata_o <= data_reg;
                default:          reg_rdata_o <= 8'h00;
            endcase
        end
    end

    a_addr_increment: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ12]
        wr_data |=> {addr_hi_reg, addr_lo_reg} == $past({addr_hi_reg, addr_lo_reg}) + 16'h0001)
        else $error("Address did not advance after a data write");
    // Checked at the FIFO head on a write into an empty FIFO, so a wrong packing or a lost push there is caught end to end.
    a_word_address: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ11]
        wr_data && !wave_valid_o
        |=> wave_valid_o && wave_addr_o == $past({addr_hi_reg, addr_lo_reg})
            && wave_data_o == $past(reg_wdata_i))
        else $error("Stored word carries the wrong address");
    a_monitor_frozen: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ7]
        !playing_i && !reg_wr_i |=> $stable(supply_reg) && $stable(period_reg))
        else $error("Monitor changed while idle");
    a_monitor_update: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ6]
        playing_i && monitor_strobe_i |=> supply_reg == $past(supply_sample_i))
        else $error("Supply reading not refreshed");
    a_period_update: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ8]
        playing_i && monitor_strobe_i |=> period_reg == $past(period_sample_i))
        else $error("Period reading not refreshed");
    a_nvm_once: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ5]
        nvm_done_reg |=> nvm_done_reg && !nvm_copy_o)
        else $error("One-time memory relaunched");
    a_nvm_launch: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ4]
        nvm_state_reg == HCM_NVM_IDLE && !nvm_programmed_i && reg_wr_i
        && reg_addr_i == `HCM_OFS_CTRL && reg_wdata_i[0]
        |=> nvm_copy_o && nvm_copy_addr_o == `HCM_OFS_NVM_FIRST)
        else $error("Programming did not start");
    a_ctrl_reserved: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ14]
        reg_rd_i && reg_addr_i == `HCM_OFS_CTRL
        |=> reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[3] == 1'b0
            && reg_rdata_o[1:0] == 2'b00)
        else $error("Reserved control bits read nonzero");
    a_cal_field: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ1]
        reg_wr_i && reg_addr_i == `HCM_OFS_CTRL
        |=> cal_time_sel_o == $past(reg_wdata_i[5:4]))
        else $error("Calibration field not written");

    c_burst: cover property (@(posedge core_clk_i) wr_data ##1 wr_data ##1 wr_data);
    c_full: cover property (@(posedge core_clk_i) fifo_full);
    c_nvm_done: cover property (@(posedge core_clk_i) $rose(nvm_done_reg));
    c_monitor: cover property (@(posedge core_clk_i) playing_i && monitor_strobe_i);
endmodule : hcm_regs
`default_nettype wire

/* File: verification/hcm_far_model.sv */
/*
 Far-side model: the waveform memory that pops the write FIFO and the one-time
 memory programmer that acknowledges copy bytes. Assumes the register group's
 core clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hcm_far_model (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        stall_i,
    input  wire logic        wave_valid_i,
    input  wire logic [15:0] wave_addr_i,
    input  wire logic [7:0]  wave_data_i,
    output logic             wave_ready_o,
    input  wire logic        nvm_copy_i,
    input  wire logic [7:0]  nvm_copy_addr_i,
    output logic             nvm_copy_ack_o
);
    logic [23:0] words [$];
    logic [7:0]  copied [$];
    // A stalled memory refuses every word, so the FIFO can be filled.
    assign wave_ready_o = !stall_i;
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            nvm_copy_ack_o <= 1'b0;
        end else begin
            // Acks every other cycle, a slow programmer rather than an instant one.
            nvm_copy_ack_o <= nvm_copy_i && !nvm_copy_ack_o;
            if (nvm_copy_i && nvm_copy_ack_o) begin
                copied.push_back(nvm_copy_addr_i);
            end
            if (wave_valid_i && wave_ready_o) begin
                words.push_back({wave_addr_i, wave_data_i});
            end
        end
    end
endmodule : hcm_far_model
`default_nettype wire

/* File: verification/haptic_cal_monitor_wave_ram_regs_test.sv */
/*
 Self-checking bench for the register group: control field, monitors, waveform
 memory write port with its FIFO, and one-time memory launch.
 Assumes the register group and the far-side model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module haptic_cal_monitor_wave_ram_regs_test
    import hcm_pkg::*;
;
    logic        core_clk_i, srst_i, reg_wr_i, reg_rd_i, playing_i, monitor_strobe_i;
    logic        nvm_programmed_i, reg_wr_ready_o, nvm_copy_o, nvm_copy_ack_i;
    logic        wave_valid_o, wave_ready_i, stall;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, supply_sample_i, period_sample_i;
    logic [7:0]  nvm_copy_addr_o, wave_data_o;
    logic [1:0]  cal_time_sel_o;
    logic [31:0] cal_min_cycles_o;
    logic [15:0] wave_addr_o;
    int          failures, checked;
    int          ms [4] = '{150, 250, 500, 1000};

    hcm_regs #(.FIFO_DEPTH(8), .NVM_BYTES(5)) u_dut (.core_clk_i(core_clk_i),
        .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_wr_ready_o(reg_wr_ready_o),
        .playing_i(playing_i), .monitor_strobe_i(monitor_strobe_i),
        .supply_sample_i(supply_sample_i), .period_sample_i(period_sample_i),
        .nvm_programmed_i(nvm_programmed_i), .nvm_copy_o(nvm_copy_o),
        .nvm_copy_addr_o(nvm_copy_addr_o), .nvm_copy_ack_i(nvm_copy_ack_i),
        .cal_time_sel_o(cal_time_sel_o), .cal_min_cycles_o(cal_min_cycles_o),
        .wave_valid_o(wave_valid_o), .wave_ready_i(wave_ready_i),
        .wave_addr_o(wave_addr_o), .wave_data_o(wave_data_o));
    hcm_far_model u_model (.core_clk_i(core_clk_i), .srst_i(srst_i), .stall_i(stall),
        .wave_valid_i(wave_valid_o), .wave_addr_i(wave_addr_o), .wave_data_i(wave_data_o),
        .wave_ready_o(wave_ready_i), .nvm_copy_i(nvm_copy_o),
        .nvm_copy_addr_i(nvm_copy_addr_o), .nvm_copy_ack_o(nvm_copy_ack_i));

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // Every bus task starts and ends on a falling edge and leaves one idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
        @(negedge core_clk_i);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, exp);
        @(negedge core_clk_i);
    endtask : rdchk

    task automatic wait_for(input int n, input bit nvm);
        int k;
        for (k = 0; k < 200 && (nvm ? u_model.copied.size() : u_model.words.size()) < n; k++)
            @(negedge core_clk_i);
        if (k == 200) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
    endtask : wait_for

    task automatic sample(input logic p, input logic [7:0] s, input logic [7:0] q);
        playing_i = p;
        supply_sample_i = s;
        period_sample_i = q;
        monitor_strobe_i = 1'b1;
        @(negedge core_clk_i);
        monitor_strobe_i = 1'b0;
        @(negedge core_clk_i);
    endtask : sample

    task automatic t_reset;
        rdchk(8'h1E, 8'h20);
        rdchk(8'h21, 8'h00);
        rdchk(8'h22, 8'h00);
        rdchk(8'hFD, 8'h00);
        rdchk(8'hFE, 8'h00);
        rdchk(8'h40, 8'h00);
        $display("test reset_values done");
    endtask : t_reset

    task automatic t_cal;
        for (int i = 0; i < 4; i++) begin
            wr(8'h1E, {2'b11, i[1:0], 4'hE});
            rdchk(8'h1E, {2'b00, i[1:0], 4'h0});
            chk(cal_time_sel_o, i);
            chk(cal_min_cycles_o, ms[i] * 40000);
        end
        wr(8'h1E, 8'h20);
        chk(cal_min_cycles_o, ms[2] * 40000);
        $display("test calibration_field done");
    endtask : t_cal

    task automatic t_monitor;
        sample(1'b0, 8'h11, 8'h22);
        rdchk(8'h21, 8'h00);
        wr(8'h22, 8'h5A);
        rdchk(8'h22, 8'h5A);
        sample(1'b1, 8'hC3, 8'h3C);
        rdchk(8'h21, 8'hC3);
        rdchk(8'h22, 8'h3C);
        sample(1'b0, 8'h99, 8'h66);
        rdchk(8'h21, 8'hC3);
        $display("test monitors done");
    endtask : t_monitor

    // Bytes go back to back in one strobe run; the high byte must take the carry.
    task automatic t_burst;
        wr(8'hFD, 8'h12);
        wr(8'hFE, 8'hFF);
        u_model.words.delete();
        reg_wr_i = 1'b1;
        reg_addr_i = 8'hFF;
        for (int i = 0; i < 3; i++) begin
            reg_wdata_i = 8'hA1 + i[7:0];
            @(negedge core_clk_i);
        end
        reg_wr_i = 1'b0;
        wait_for(3, 1'b0);
        chk(u_model.words[0], 24'h12FFA1);
        chk(u_model.words[1], 24'h1300A2);
        chk(u_model.words[2], 24'h1301A3);
        rdchk(8'hFD, 8'h13);
        rdchk(8'hFE, 8'h02);
        $display("test burst_write done");
    endtask : t_burst

    // A ninth byte into a stalled eight-word FIFO is dropped and must not advance the address.
    task automatic t_full;
        stall = 1'b1;
        wr(8'hFD, 8'h00);
        wr(8'hFE, 8'h00);
        u_model.words.delete();
        reg_wr_i = 1'b1;
        reg_addr_i = 8'hFF;
        for (int i = 0; i < 9; i++) begin
            chk(reg_wr_ready_o, i < 8);
            reg_wdata_i = 8'h10 + i[7:0];
            @(negedge core_clk_i);
        end
        reg_wr_i = 1'b0;
        rdchk(8'hFE, 8'h08);
        stall = 1'b0;
        wait_for(8, 1'b0);
        @(negedge core_clk_i);
        chk(u_model.words.size(), 8);
        chk(u_model.words[7], 24'h000717);
        chk(wave_valid_o, 1'b0);
        rdchk(8'hFF, 8'h17);
        $display("test fifo_full done");
    endtask : t_full

    task automatic t_nvm;
        wr(8'h1E, 8'h21);
        wait_for(5, 1'b1);
        for (int i = 0; i < 5; i++) chk(u_model.copied[i], 8'h16 + i);
        repeat (2) @(negedge core_clk_i);
        rdchk(8'h1E, 8'h24);
        wr(8'h1E, 8'h21);
        chk(nvm_copy_o, 1'b0);
        nvm_programmed_i = 1'b1;
        srst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        srst_i = 1'b0;
        @(negedge core_clk_i);
        rdchk(8'h1E, 8'h24);
        wr(8'h1E, 8'h21);
        chk(nvm_copy_o, 1'b0);
        $display("test nvm_launch done");
    endtask : t_nvm

    initial begin
        {reg_wr_i, reg_rd_i, playing_i, monitor_strobe_i, nvm_programmed_i, stall} = 6'h00;
        {reg_addr_i, reg_wdata_i, supply_sample_i, period_sample_i} = 32'h0;
        failures = 0;
        checked = 0;
        srst_i = 1'b1;
        repeat (20) @(negedge core_clk_i);
        srst_i = 1'b0;
        t_reset();
        t_cal();
        t_monitor();
        t_burst();
        t_full();
        t_nvm();
        wrap_up();
    end
endmodule : haptic_cal_monitor_wave_ram_regs_test
`default_nettype wire
